// File: amrc_pkg.sv
// constants and types for the converter mode and reference control
// What this block does
// - the option bit and rate field together pick one of eight modes.
// - each conversion measures all inputs, then calibrates each channel.
// - the fast mode uses the smallest oversampling ratio, corner 27kHz.
// - the filtered mode uses the largest oversampling ratio, corner 26Hz.
// - six middle modes sit at 13.5kHz, 6.8kHz, 3.4kHz, 1.7kHz, 845Hz and 422Hz.
// - a command taken in standby waits the reference warm-up time first.
// - with the hold bit set the reference stays up and the core goes ready.
// - a command taken in the ready state starts with no warm-up.
// - after conversions the core goes ready if hold is set, else standby.
// - only conversion or diagnostic commands start measuring.
package amrc_pkg;
  typedef enum logic [2:0] {
    AMRC_M27K, AMRC_M14K, AMRC_M7K, AMRC_M3K,
    AMRC_M2K, AMRC_M1K, AMRC_M422, AMRC_M26
  } amrc_mode_e;
  typedef enum logic [1:0] {
    AMRC_CMD_OTHER, AMRC_CMD_CONV, AMRC_CMD_DIAG
  } amrc_cmd_e;
  localparam int AMRC_CLK_MHZ = 100;
  localparam int AMRC_WARMUP_US = 4400;
  localparam int AMRC_WARMUP_CYC = AMRC_WARMUP_US * AMRC_CLK_MHZ;
  localparam int AMRC_CNT_W = 32;
  // per-mode cycle counts for one input or calibration step (simulation scale)
  localparam int AMRC_OSR_BASE = 4;
  localparam int AMRC_OPT_BIT = 0;
  localparam logic [23:0] AMRC_MODE_TABLE = {
    AMRC_M2K, AMRC_M26, AMRC_M422, AMRC_M14K,
    AMRC_M1K, AMRC_M3K, AMRC_M7K, AMRC_M27K
  };
  localparam logic [15:0] AMRC_CORNER_HZ [8] = '{
    16'h6978, 16'h34BC, 16'h1A90, 16'h0D48,
    16'h06A4, 16'h034D, 16'h01A6, 16'h001A
  };
endpackage : amrc_pkg

// File: amrc_step_timer.sv
// step timer: counts one oversampled step per mode
`timescale 1ns/1ps
module amrc_step_timer #(
  parameter int BASE = 4
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic [2:0] i_mode,
  output logic o_done
);
  import amrc_pkg::*;
  typedef struct packed {
    logic [15:0] cnt;
    logic run;
    logic done;
  } amrc_tmr_s;
  amrc_tmr_s st_r;
  amrc_tmr_s st_nxt;
  logic [15:0] len;
  // ratio doubles per mode, fast shortest
  assign len = 16'(BASE) << i_mode;
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (i_start) begin
      st_nxt.run = 1'b1;
      st_nxt.cnt = len - 16'h0001;
    end else if (st_r.run) begin
      if (st_r.cnt == 16'h0000) begin
        st_nxt.run = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - 16'h0001;
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end
  assign o_done = st_r.done;
endmodule : amrc_step_timer

// File: amrc_top.sv
// core state sequencing for converter mode and reference warm-up
`timescale 1ns/1ps
module amrc_top #(
  parameter int WARMUP_CYC = amrc_pkg::AMRC_WARMUP_CYC,
  parameter int N_INPUTS = 6,
  parameter int OSR_BASE = amrc_pkg::AMRC_OSR_BASE
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_sleep,
  input wire logic i_cmd_valid,
  input wire amrc_pkg::amrc_cmd_e i_cmd_kind,
  input wire logic [1:0] i_rate_select_field,
  input wire logic [7:0] i_config_byte_zero,
  input wire logic i_reference_hold_bit,
  output logic o_ref_on,
  output logic o_reference_ready_state,
  output logic o_measuring,
  output logic o_calibrating,
  output logic o_conv_done,
  output logic [2:0] o_mode,
  output logic [15:0] o_corner_hz
);
  import amrc_pkg::*;
  typedef enum logic [2:0] {
    ST_STANDBY, ST_WARMUP, ST_REFRDY, ST_MEAS, ST_CAL
  } amrc_state_e;
  typedef struct packed {
    amrc_state_e state;
    logic [AMRC_CNT_W-1:0] wcnt;
    logic [7:0] step;
    logic [2:0] mode;
    logic go;
    logic pend;
    logic done;
  } amrc_core_s;
  amrc_core_s st_r;
  amrc_core_s st_nxt;
  logic step_done;
  logic is_adc;
  logic [2:0] sel_mode;

  assign is_adc = i_cmd_valid &&
    (i_cmd_kind == AMRC_CMD_CONV || i_cmd_kind == AMRC_CMD_DIAG);
  // option bit and rate index one table
  assign sel_mode = AMRC_MODE_TABLE[3*{i_config_byte_zero[AMRC_OPT_BIT],
    i_rate_select_field} +: 3];

  amrc_step_timer #(
    .BASE(OSR_BASE)
  ) u_tmr (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_start(st_r.go),
    .i_mode(st_r.mode),
    .o_done(step_done)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.go = 1'b0;
    st_nxt.done = 1'b0;
    case (st_r.state)
      ST_STANDBY: begin
        if (is_adc || i_reference_hold_bit) begin
          st_nxt.state = ST_WARMUP;
          st_nxt.wcnt = AMRC_CNT_W'(WARMUP_CYC - 1);
          st_nxt.pend = is_adc;
          st_nxt.mode = is_adc ? sel_mode : st_r.mode;
        end
      end
      ST_WARMUP: begin
        if (is_adc) begin
          st_nxt.pend = 1'b1;
          st_nxt.mode = sel_mode;
        end
        if (st_r.wcnt == '0) begin
          if (st_r.pend || is_adc) begin
            st_nxt.state = ST_MEAS;
            st_nxt.step = 8'h00;
            st_nxt.go = 1'b1;
            st_nxt.pend = 1'b0;
          end else begin
            st_nxt.state = ST_REFRDY;
          end
        end else begin
          st_nxt.wcnt = st_r.wcnt - 1'b1;
        end
      end
      ST_REFRDY: begin
        if (is_adc) begin
          st_nxt.state = ST_MEAS;
          st_nxt.mode = sel_mode;
          st_nxt.step = 8'h00;
          st_nxt.go = 1'b1;
        end else if (!i_reference_hold_bit) begin
          st_nxt.state = ST_STANDBY;
        end
      end
      ST_MEAS, ST_CAL: begin
        if (step_done) begin
          if (st_r.step == 8'(N_INPUTS - 1)) begin
            st_nxt.step = 8'h00;
            if (st_r.state == ST_MEAS) begin
              st_nxt.state = ST_CAL;
              st_nxt.go = 1'b1;
            end else begin
              st_nxt.done = 1'b1;
              st_nxt.state = i_reference_hold_bit ? ST_REFRDY : ST_STANDBY;
            end
          end else begin
            st_nxt.step = st_r.step + 8'h01;
            st_nxt.go = 1'b1;
          end
        end
      end
      default: st_nxt.state = ST_STANDBY;
    endcase
  end

  // sleep forces defaults, like reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '0;
    end else if (i_ce) begin
      if (i_sleep) begin
        st_r <= '0;
      end else begin
        st_r <= st_nxt;
      end
    end
  end

  assign o_ref_on = st_r.state != ST_STANDBY;
  assign o_reference_ready_state = st_r.state == ST_REFRDY;
  assign o_measuring = st_r.state == ST_MEAS;
  assign o_calibrating = st_r.state == ST_CAL;
  assign o_conv_done = st_r.done;
  assign o_mode = st_r.mode;
  assign o_corner_hz = AMRC_CORNER_HZ[st_r.mode];

  a_other_cmd_keep: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && !i_sleep && st_r.state == ST_STANDBY && !is_adc
     && !i_reference_hold_bit) |=> st_r.state == ST_STANDBY)
    else $error("non-adc command changed state");
  a_standby_warm: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && !i_sleep && st_r.state == ST_STANDBY && is_adc)
    |=> st_r.state == ST_WARMUP)
    else $error("command from standby skipped warm-up");
  a_ready_direct: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && !i_sleep && st_r.state == ST_REFRDY && is_adc)
    |=> st_r.state == ST_MEAS && st_r.go)
    else $error("ready state did not start at once");
  a_cal_after_meas: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (st_r.state == ST_CAL) |-> $past(st_r.state) inside {ST_MEAS, ST_CAL})
    else $error("calibration without measurement");
  a_done_target: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (st_r.done && $past(i_ce)) |-> st_r.state ==
      ($past(i_reference_hold_bit) ? ST_REFRDY : ST_STANDBY))
    else $error("bad state after conversion");
  a_hold_ready: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && !i_sleep && st_r.state == ST_WARMUP && st_r.wcnt == '0
     && !st_r.pend && !is_adc) |=> st_r.state == ST_REFRDY)
    else $error("held reference did not reach ready");
  a_mode_table: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && !i_sleep && st_r.state == ST_REFRDY && is_adc)
    |=> st_r.mode == $past(sel_mode))
    else $error("mode not taken from table");
  a_fast_corner: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (o_mode == AMRC_M27K) |-> o_corner_hz == 16'h6978)
    else $error("fast corner wrong");
  a_filt_corner: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (o_mode == AMRC_M26) |-> o_corner_hz == 16'h001A)
    else $error("filtered corner wrong");
  a_mid_corner: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (o_mode == AMRC_M1K) |-> o_corner_hz == 16'h034D)
    else $error("845Hz corner wrong");
  a_warm_hold: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && !i_sleep && st_r.state == ST_WARMUP && st_r.wcnt != '0)
    |=> st_r.state == ST_WARMUP)
    else $error("warm-up cut short");
  a_meas_to_cal: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && !i_sleep && st_r.state == ST_MEAS && step_done
     && st_r.step == 8'(N_INPUTS - 1)) |=> st_r.state == ST_CAL)
    else $error("no calibration after inputs");
  a_done_after_cal: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (st_r.done && $past(i_ce)) |-> $past(st_r.state) == ST_CAL)
    else $error("done without calibration");
  a_busy_ignore: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && !i_sleep && st_r.state == ST_MEAS && !step_done)
    |=> st_r.state == ST_MEAS && st_r.mode == $past(st_r.mode))
    else $error("busy core changed state or mode");
  a_mode_standby: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && !i_sleep && st_r.state == ST_STANDBY && is_adc)
    |=> st_r.mode == $past(sel_mode))
    else $error("standby mode not taken from table");
endmodule : amrc_top

// File: amrc_host_model.sv
// host model: issues one-cycle command pulses
`timescale 1ns/1ps
module amrc_host_model (
  input wire logic i_clk,
  output logic o_cmd_valid,
  output amrc_pkg::amrc_cmd_e o_cmd_kind,
  output logic [1:0] o_rate
);
  import amrc_pkg::*;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_kind = AMRC_CMD_OTHER;
    o_rate = 2'h0;
  end
  // rate inverted when idle, so a stale field is never read as valid
  task automatic send(input amrc_cmd_e k, input logic [1:0] r);
    @(posedge i_clk);
    o_cmd_valid <= 1'b1;
    o_cmd_kind <= k;
    o_rate <= r;
    @(posedge i_clk);
    o_cmd_valid <= 1'b0;
    o_rate <= ~r;
  endtask : send
endmodule : amrc_host_model

// File: test_adc_mode_and_reference_control.sv
// self-checking bench for mode and reference control
`timescale 1ns/1ps
module test_adc_mode_and_reference_control;
  import amrc_pkg::*;
  localparam int WU = 8;
  typedef struct {
    logic opt;
    logic [1:0] rate;
    logic hold;
    amrc_cmd_e kind;
    logic [15:0] mode;
    logic [15:0] hz;
  } amrc_row_s;
  logic i_clk, i_arst_n, i_ce, i_sleep, i_hold, cv, ref_on, rdy, meas, cal;
  logic done, prev;
  logic [7:0] i_cfg;
  logic [1:0] cr;
  logic [2:0] mode;
  logic [15:0] corner;
  amrc_cmd_e ck;
  int err_total = 0;
  int samples_checked = 0;
  amrc_row_s rows [8] = '{
    '{1'b0, 2'h0, 1'b1, AMRC_CMD_CONV, 16'h0, 16'h6978},
    '{1'b0, 2'h1, 1'b1, AMRC_CMD_DIAG, 16'h2, 16'h1A90},
    '{1'b0, 2'h2, 1'b0, AMRC_CMD_CONV, 16'h3, 16'h0D48},
    '{1'b0, 2'h3, 1'b1, AMRC_CMD_DIAG, 16'h5, 16'h034D},
    '{1'b1, 2'h0, 1'b0, AMRC_CMD_CONV, 16'h1, 16'h34BC},
    '{1'b1, 2'h1, 1'b0, AMRC_CMD_DIAG, 16'h6, 16'h01A6},
    '{1'b1, 2'h2, 1'b1, AMRC_CMD_CONV, 16'h7, 16'h001A},
    '{1'b1, 2'h3, 1'b0, AMRC_CMD_DIAG, 16'h4, 16'h06A4}};
  amrc_host_model host (.i_clk(i_clk), .o_cmd_valid(cv), .o_cmd_kind(ck),
    .o_rate(cr));
  amrc_top #(.WARMUP_CYC(WU), .N_INPUTS(2), .OSR_BASE(4)) uut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_sleep(i_sleep),
    .i_cmd_valid(cv), .i_cmd_kind(ck), .i_rate_select_field(cr),
    .i_config_byte_zero(i_cfg), .i_reference_hold_bit(i_hold),
    .o_ref_on(ref_on), .o_reference_ready_state(rdy), .o_measuring(meas),
    .o_calibrating(cal), .o_conv_done(done), .o_mode(mode),
    .o_corner_hz(corner));
  task automatic chk_bit(input logic g, input logic e, input string s);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, s);
    end
  endtask : chk_bit
  task automatic chk_val(input logic [15:0] g, input logic [15:0] e,
    input string s);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t %s got %h want %h", $time, s, g, e);
    end
  endtask : chk_val
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask : tick
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // hold is changed only after the command is taken
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 4000) begin
      tick(1);
      n++;
    end
    chk_bit(done, 1'b1, "done");
  endtask : wait_done
  task automatic run(input amrc_cmd_e k, input logic [1:0] r,
    input logic h, input int ew);
    int w;
    int n;
    host.send(k, r);
    i_hold <= h;
    #1;
    w = 0;
    while (meas !== 1'b1 && w < 40) begin
      tick(1);
      w++;
    end
    chk_val(w[15:0], ew[15:0], "start delay");
    n = 0;
    while (cal !== 1'b1 && n < 4000) begin
      tick(1);
      n++;
    end
    chk_bit(cal & ~meas, 1'b1, "measure then cal");
    wait_done();
    chk_bit(rdy, h, "end state");
    chk_bit(ref_on, h, "ref kept");
    tick(1);
    chk_bit(done, 1'b0, "done pulse");
  endtask : run
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #500000;
    err_total++;
    summarize();
  end
  initial begin
    i_arst_n = 1'b0;
    i_ce = 1'b1;
    i_sleep = 1'b0;
    i_hold = 1'b0;
    i_cfg = 8'h00;
    prev = 1'b0;
    tick(12);
    chk_bit(ref_on | rdy | meas | cal | done, 1'b0, "reset");
    @(posedge i_clk);
    i_arst_n <= 1'b1;
    host.send(AMRC_CMD_OTHER, 2'h0);
    tick(WU + 4);
    chk_bit(ref_on | meas, 1'b0, "other cmd");
    foreach (rows[i]) begin
      @(posedge i_clk);
      i_cfg <= {7'h00, rows[i].opt};
      run(rows[i].kind, rows[i].rate, rows[i].hold, prev ? 0 : WU);
      chk_val({13'h0, mode}, rows[i].mode, "mode");
      chk_val(corner, rows[i].hz, "corner");
      prev = rows[i].hold;
    end
    @(posedge i_clk);
    i_hold <= 1'b1;
    tick(2);
    chk_bit(ref_on & ~rdy, 1'b1, "warming");
    tick(WU + 2);
    chk_bit(rdy, 1'b1, "ready");
    @(posedge i_clk);
    i_cfg <= 8'h00;
    host.send(AMRC_CMD_CONV, 2'h0);
    host.send(AMRC_CMD_CONV, 2'h3);
    wait_done();
    tick(2);
    chk_val({13'h0, mode}, 16'h0, "busy cmd dropped");
    chk_bit(meas, 1'b0, "no rerun");
    @(posedge i_clk);
    i_sleep <= 1'b1;
    tick(2);
    chk_bit(ref_on | rdy, 1'b0, "sleep");
    @(posedge i_clk);
    i_sleep <= 1'b0;
    tick(WU + 4);
    chk_bit(rdy, 1'b1, "wake ready");
    // clock enable low: a command must be lost, state frozen
    @(posedge i_clk);
    i_ce <= 1'b0;
    host.send(AMRC_CMD_CONV, 2'h0);
    tick(2);
    chk_bit(meas | ~rdy, 1'b0, "frozen");
    @(posedge i_clk);
    i_ce <= 1'b1;
    // second reset while the core sits idle in the ready state
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    i_hold <= 1'b0;
    tick(2);
    chk_bit(ref_on | rdy | meas | cal | done, 1'b0, "mid reset");
    @(posedge i_clk);
    i_arst_n <= 1'b1;
    run(AMRC_CMD_DIAG, 2'h1, 1'b0, WU);
    chk_val({13'h0, mode}, 16'h2, "mode after reset");
    summarize();
  end
endmodule : test_adc_mode_and_reference_control
